// File: pmcap_regs.sv
`timescale 1ns/10ps
module pmcap_regs
(
   // Clock and power-on reset
   input  wire  logic                  clk,
   input  wire  logic                  srst,
   // Non-sticky resets and stop command
   input  wire  logic                  hw_reset,
   input  wire  logic                  sw_reset,
   input  wire  logic                  stop_cmd,
   // Configuration access from host side
   input  wire  pmcap_pkg::pmcap_req_s cfg_req,
   output       pmcap_pkg::pmcap_rsp_s cfg_rsp,
   // EEPROM load of the capability word
   input  wire  logic                  eeprom_load,
   input  wire  logic [15:0]           eeprom_cap_word,
   // Internal test alias of the capability word
   input  wire  logic                  test_alias_wr,
   input  wire  logic [15:0]           test_alias_wdata,
   output       logic [15:0]           capability_test_alias,
   // Wake detection and data item
   input  wire  logic                  wake_event,
   input  wire  logic [1:0]            data_scale,
   output       logic [3:0]            data_select,
   output       logic [1:0]            power_state_field,
   // Active-low wake pin
   output       logic                  wake_n
);

   // Stored capability word, shared with the test alias
   logic [15:0] power_mgmt_capabilities;
   // Sticky control/status fields
   logic        wake_status;
   logic        wake_enable;
   // Capability word as presented to the host
   logic [15:0] cap_view;
   // Control/status word as presented to the host
   logic [15:0] csr_view;
   // Decoded accesses
   logic        hit_cap;
   logic        hit_csr;
   logic        csr_wr_hi;
   logic        csr_wr_lo;
   logic        clear_req;
   // Registered answer
   pmcap_pkg::pmcap_rsp_s rsp_q;

   // Word decode: byte offset rounded down to the even word
   function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] base);
      word_hit = (addr[7:1] == base[7:1]);
   endfunction

   // Field views of the capability word
   logic [4:0]  wake_state_support_mask;
   logic        deep_doze_supported;
   logic        light_doze_supported;
   logic        init_required;
   logic        aux_power_required;
   logic        wake_needs_bus_clock;
   logic [2:0]  pm_interface_version;

   always_comb
   begin
      wake_state_support_mask = power_mgmt_capabilities[pmcap_pkg::CAP_MASK_HI:pmcap_pkg::CAP_MASK_LO];
      deep_doze_supported     = power_mgmt_capabilities[pmcap_pkg::CAP_DEEP_BIT];
      light_doze_supported    = power_mgmt_capabilities[pmcap_pkg::CAP_LIGHT_BIT];
      init_required           = power_mgmt_capabilities[pmcap_pkg::CAP_INIT_BIT];
      // Aux power only means something with D3cold wake
      aux_power_required      = power_mgmt_capabilities[pmcap_pkg::CAP_AUX_BIT]
                                & power_mgmt_capabilities[pmcap_pkg::CAP_D3COLD_BIT];
      // No wake anywhere means no clock dependence either
      wake_needs_bus_clock    = power_mgmt_capabilities[pmcap_pkg::CAP_CLK_BIT]
                                & (|wake_state_support_mask);
      // Version is fixed whatever the EEPROM holds
      pm_interface_version    = pmcap_pkg::PM_VERSION;
   end

   // Assemble the capability word; reserved bits read as zero
   always_comb
   begin
      cap_view = '0;
      cap_view[pmcap_pkg::CAP_MASK_HI:pmcap_pkg::CAP_MASK_LO] = wake_state_support_mask;
      cap_view[pmcap_pkg::CAP_DEEP_BIT]  = deep_doze_supported;
      cap_view[pmcap_pkg::CAP_LIGHT_BIT] = light_doze_supported;
      cap_view[pmcap_pkg::CAP_INIT_BIT]  = init_required;
      cap_view[pmcap_pkg::CAP_AUX_BIT]   = aux_power_required;
      cap_view[pmcap_pkg::CAP_CLK_BIT]   = wake_needs_bus_clock;
      cap_view[pmcap_pkg::CAP_VER_HI:pmcap_pkg::CAP_VER_LO] = pm_interface_version;
   end

   // Assemble the control/status word; bits 7-2 read as zero
   always_comb
   begin
      csr_view = '0;
      csr_view[pmcap_pkg::CSR_STATUS_BIT] = wake_status;
      csr_view[pmcap_pkg::CSR_SCALE_HI:pmcap_pkg::CSR_SCALE_LO] = data_scale;
      csr_view[pmcap_pkg::CSR_SEL_HI:pmcap_pkg::CSR_SEL_LO] = data_select;
      csr_view[pmcap_pkg::CSR_ENABLE_BIT] = wake_enable;
      csr_view[pmcap_pkg::CSR_STATE_HI:pmcap_pkg::CSR_STATE_LO] = power_state_field;
   end

   // Access decode
   always_comb
   begin
      hit_cap   = word_hit(cfg_req.addr, pmcap_pkg::OFF_CAPABILITIES);
      hit_csr   = word_hit(cfg_req.addr, pmcap_pkg::OFF_CONTROL_STATUS);
      // Upper lane carries status, select and enable
      csr_wr_hi = cfg_req.wr & hit_csr & cfg_req.be[1];
      // Lower lane carries the power state only
      csr_wr_lo = cfg_req.wr & hit_csr & cfg_req.be[0];
      clear_req = csr_wr_hi & cfg_req.wdata[pmcap_pkg::CSR_STATUS_BIT];
   end

   // Capability storage: host writes ignored, EEPROM or test alias load it
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         power_mgmt_capabilities <= pmcap_pkg::CAP_RESET;
      end
      else if (eeprom_load)
      begin
         // EEPROM wins over a simultaneous test write
         power_mgmt_capabilities <= eeprom_cap_word;
      end
      else if (test_alias_wr)
      begin
         power_mgmt_capabilities <= test_alias_wdata;
      end
   end

   // Test alias is the same storage, not a copy that could drift
   assign capability_test_alias = power_mgmt_capabilities;

   // Wake status: sticky, set by event, cleared by writing one
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // Only power-on reset reaches this flag
         wake_status <= 1'b0;
      end
      else if (wake_event)
      begin
         // Set wins over a clear in the same cycle, so no event is lost
         wake_status <= 1'b1;
      end
      else if (clear_req)
      begin
         // A zero written here leaves the flag alone
         wake_status <= 1'b0;
      end
   end

   // Wake enable and data select: sticky, host read/write
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // Enable starts off, as needed when D3cold wake is absent
         wake_enable <= 1'b0;
         data_select <= pmcap_pkg::SEL_RESET;
      end
      else if (csr_wr_hi)
      begin
         wake_enable <= cfg_req.wdata[pmcap_pkg::CSR_ENABLE_BIT];
         data_select <= cfg_req.wdata[pmcap_pkg::CSR_SEL_HI:pmcap_pkg::CSR_SEL_LO];
      end
   end

   // Power state: stored only; hardware reset returns it to D0
   always_ff @(posedge clk)
   begin
      if (srst || hw_reset)
      begin
         // Software reset and stop leave the state as it was
         power_state_field <= pmcap_pkg::PM_D0;
      end
      else if (csr_wr_lo)
      begin
         // Nothing else in the block looks at this field
         power_state_field <= cfg_req.wdata[pmcap_pkg::CSR_STATE_HI:pmcap_pkg::CSR_STATE_LO];
      end
   end

   // Registered answer, one cycle after the access is taken
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rsp_q <= '0;
      end
      else
      begin
         rsp_q.ack <= cfg_req.rd | cfg_req.wr;
         rsp_q.hit <= (cfg_req.rd | cfg_req.wr) & (hit_cap | hit_csr);
         if (cfg_req.rd && hit_cap)
         begin
            rsp_q.rdata <= cap_view;
         end
         else if (cfg_req.rd && hit_csr)
         begin
            rsp_q.rdata <= csr_view;
         end
         else
         begin
            // Unmapped reads and all writes return zero
            rsp_q.rdata <= '0;
         end
      end
   end

   assign cfg_rsp = rsp_q;

   // Wake pin: low only while status and enable are both set
   assign wake_n = ~(wake_status & wake_enable);

   // A wake event always shows in status next cycle
   chk_event_sets_status: assert property (@(posedge clk) disable iff (srst)
      wake_event |=> wake_status)
      else $error("wake event did not set status");

   // Writing one clears status when no event competes
   chk_one_clears_status: assert property (@(posedge clk) disable iff (srst)
      (clear_req && !wake_event) |=> !wake_status ##0 wake_n)
      else $error("write of one did not clear status");

   // Writing zero to status keeps a pending flag
   chk_zero_keeps_status: assert property (@(posedge clk) disable iff (srst)
      (csr_wr_hi && !cfg_req.wdata[pmcap_pkg::CSR_STATUS_BIT] && wake_status) |=> wake_status)
      else $error("write of zero disturbed status");

   // Pin stays released while enable is off
   chk_pin_blocked: assert property (@(posedge clk) disable iff (srst)
      !wake_enable |-> wake_n)
      else $error("wake pin asserted while disabled");

   // Pin drops in the cycle status rises under enable
   chk_pin_follows: assert property (@(posedge clk) disable iff (srst)
      ($rose(wake_status) && wake_enable) |-> !wake_n)
      else $error("wake pin did not follow status");

   // Capability read: aux bit zero without D3cold flag
   chk_aux_masked: assert property (@(posedge clk) disable iff (srst)
      (cfg_req.rd && hit_cap && !power_mgmt_capabilities[pmcap_pkg::CAP_D3COLD_BIT])
      |=> rsp_q.ack && !rsp_q.rdata[pmcap_pkg::CAP_AUX_BIT])
      else $error("aux power bit not masked");

   // Capability read: clock bit zero without any wake support
   chk_clock_masked: assert property (@(posedge clk) disable iff (srst)
      (cfg_req.rd && hit_cap && (wake_state_support_mask == '0))
      |=> !rsp_q.rdata[pmcap_pkg::CAP_CLK_BIT])
      else $error("clock bit not masked");

   // Capability read always carries version 001b
   chk_version_field: assert property (@(posedge clk) disable iff (srst)
      (cfg_req.rd && hit_cap) |=> rsp_q.rdata[pmcap_pkg::CAP_VER_HI:pmcap_pkg::CAP_VER_LO] == pmcap_pkg::PM_VERSION)
      else $error("version field wrong");

   // Status read shows zero in reserved bits 7-2
   chk_reserved_zero: assert property (@(posedge clk) disable iff (srst)
      (cfg_req.rd && hit_csr) |=> rsp_q.rdata[pmcap_pkg::CSR_ENABLE_BIT-1:pmcap_pkg::CSR_STATE_HI+1] == '0)
      else $error("reserved status bits not zero");

   // Other resets and stop leave the sticky fields alone
   chk_sticky_hold: assert property (@(posedge clk) disable iff (srst)
      ((hw_reset || sw_reset || stop_cmd) && !wake_event && !csr_wr_hi)
      |=> $stable(wake_status) && $stable(wake_enable) && $stable(data_select))
      else $error("sticky field changed without power-on reset");

   // EEPROM load appears on the test alias next cycle
   chk_alias_mirror: assert property (@(posedge clk) disable iff (srst)
      eeprom_load |=> capability_test_alias == $past(eeprom_cap_word))
      else $error("test alias does not mirror load");

   // Host write to the capability word changes nothing
   chk_cap_read_only: assert property (@(posedge clk) disable iff (srst)
      (cfg_req.wr && hit_cap && !eeprom_load && !test_alias_wr) |=> $stable(power_mgmt_capabilities))
      else $error("host write altered capability word");

endmodule // pmcap_regs

// File: pmcap_pkg.sv
// Notes on behaviour
// - Capability word at 42h, EEPROM loaded, test-mirrored
// - Bits 15-11 flag wake per power state
// - Bit 10 deep doze, bit 9 light doze
// - Bit 5 flags device-specific initialization needed
// - Bit 4 reads zero unless D3cold wake flagged
// - Bit 3 flags wake needs bus clock
// - No wake support anywhere forces bit 3 zero
// - Bits 2-0 always read 001b
// - Wake event sets status bit 15 regardless
// - Write one clears wake status, zero ignored
// - Status, data select, enable survive all but power-on
// - Bits 14-13 read-only scale, follows data select
// - Bits 12-9 read/write data select
// - Wake pin asserts only while bit 8 set
// - Wake enable defaults to zero
// - Bits 1-0 power state, stored, no effect
// - Reserved capability 8-6, status 7-2 read-only
package pmcap_pkg;

   // Configuration offsets of the two words
   localparam logic [7:0]  OFF_CAPABILITIES   = 8'h42;
   localparam logic [7:0]  OFF_CONTROL_STATUS = 8'h44;

   // Capability word field positions
   localparam int          CAP_D3COLD_BIT     = 15;
   localparam int          CAP_MASK_HI        = 15;
   localparam int          CAP_MASK_LO        = 11;
   localparam int          CAP_DEEP_BIT       = 10;
   localparam int          CAP_LIGHT_BIT      = 9;
   localparam int          CAP_RES_HI         = 8;
   localparam int          CAP_RES_LO         = 6;
   localparam int          CAP_INIT_BIT       = 5;
   localparam int          CAP_AUX_BIT        = 4;
   localparam int          CAP_CLK_BIT        = 3;
   localparam int          CAP_VER_HI         = 2;
   localparam int          CAP_VER_LO         = 0;
   localparam logic [2:0]  PM_VERSION         = 3'h1;
   localparam logic [15:0] CAP_RESET          = 16'h0001;

   // Control/status word field positions
   localparam int          CSR_STATUS_BIT     = 15;
   localparam int          CSR_SCALE_HI       = 14;
   localparam int          CSR_SCALE_LO       = 13;
   localparam int          CSR_SEL_HI         = 12;
   localparam int          CSR_SEL_LO         = 9;
   localparam int          CSR_ENABLE_BIT     = 8;
   localparam int          CSR_STATE_HI       = 1;
   localparam int          CSR_STATE_LO       = 0;
   localparam logic [3:0]  SEL_RESET          = 4'h0;

   // Power state encoding
   typedef enum logic [1:0] {PM_D0 = 2'h0, PM_D1 = 2'h1, PM_D2 = 2'h2, PM_D3 = 2'h3} pmcap_state_e;

   // One configuration access, word wide with byte enables
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } pmcap_req_s;

   // Registered answer to an access
   typedef struct packed {
      logic        ack;
      logic        hit;
      logic [15:0] rdata;
   } pmcap_rsp_s;

endpackage

// File: pmcap_host_model.sv
`timescale 1ns/10ps
module pmcap_host_model
(
   // Clock
   input  wire logic                  clk,
   // Configuration access toward the device
   output      pmcap_pkg::pmcap_req_s cfg_req,
   input  wire pmcap_pkg::pmcap_rsp_s cfg_rsp
);
   // Idle bus at time zero
   initial cfg_req = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, be: 2'h0, wdata: 16'h0000};

   // One access: strobe held over one taking edge, answer sampled one cycle later
   task automatic access(input logic rd, input logic wr, input logic [7:0] addr,
                         input logic [1:0] be, input logic [15:0] wdata,
                         output pmcap_pkg::pmcap_rsp_s rsp);
      @(negedge clk);
      cfg_req = '{rd: rd, wr: wr, addr: addr, be: be, wdata: wdata};
      @(negedge clk);
      rsp = cfg_rsp;
      // Released lines show inverted data so stale values never look valid
      cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, be: ~be, wdata: ~wdata};
   endtask
endmodule // pmcap_host_model

// File: pmcap_regs_tb_top.sv
`timescale 1ns/10ps
module pmcap_regs_tb_top;
   logic                  clk, srst, hw_reset, sw_reset, stop_cmd;   // Clock and resets
   logic                  eeprom_load, test_alias_wr, wake_event;    // Side strobes
   logic [15:0]           eeprom_cap_word, test_alias_wdata;         // Side data
   logic [1:0]            data_scale;                                // Scale fed back in
   logic [15:0]           capability_test_alias;                     // Raw capability mirror
   logic [3:0]            data_select;                               // Selected data item
   logic [1:0]            power_state_field;                         // Stored power state
   logic                  wake_n;                                    // Wake pin, active low
   pmcap_pkg::pmcap_req_s cfg_req;                                   // Host request
   pmcap_pkg::pmcap_rsp_s cfg_rsp;                                   // Device answer
   int                    err_count, comparisons, seed, i;           // Bookkeeping
   logic [15:0]           cap_m, w, d;                               // Model capability, scratch
   logic [1:0]            b;                                         // Scratch lanes
   int                    status, en, sel, state;                    // Model control/status
   pmcap_pkg::pmcap_rsp_s r;                                         // Last answer

   pmcap_regs dut (.clk(clk), .srst(srst), .hw_reset(hw_reset), .sw_reset(sw_reset), .stop_cmd(stop_cmd),
      .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .eeprom_load(eeprom_load), .eeprom_cap_word(eeprom_cap_word),
      .test_alias_wr(test_alias_wr), .test_alias_wdata(test_alias_wdata),
      .capability_test_alias(capability_test_alias), .wake_event(wake_event), .data_scale(data_scale),
      .data_select(data_select), .power_state_field(power_state_field), .wake_n(wake_n));
   pmcap_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

   // Free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Verdict and end of run
   task automatic complete_run();
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Single comparison point
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Capability as the host must see it after read masking
   function automatic logic [15:0] cap_view();
      logic [15:0] v;
      v = cap_m;
      v[4] = cap_m[4] & cap_m[15];
      v[3] = cap_m[3] & (|cap_m[15:11]);
      v[8:6] = 3'h0;
      v[2:0] = 3'h1;
      return v;
   endfunction

   // Control/status word built from the model fields
   function automatic logic [15:0] csr_view();
      return {status[0], data_scale, sel[3:0], en[0], 6'h00, state[1:0]};
   endfunction

   // Read with answer checks common to every access
   task automatic rd(input logic [7:0] a);
      host.access(1'b1, 1'b0, a, 2'h3, 16'h0000, r);
      check("ack", {15'h0, r.ack}, 16'h0001);
   endtask

   // Write and model update; only the control/status word is writable
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] dv);
      host.access(1'b0, 1'b1, a, be, dv, r);
      check("wr_ack", {15'h0, r.ack}, 16'h0001);
      if (a[7:1] == 7'h22 && be[1])
      begin
         if (dv[15])
            status = 0;
         sel = dv[12:9];
         en = dv[8];
      end
      if (a[7:1] == 7'h22 && be[0])
         state = dv[1:0];
   endtask

   // Both words through the bus plus every output pin
   task automatic check_all();
      rd(8'h42);
      check("cap", r.rdata, cap_view());
      check("cap_hit", {15'h0, r.hit}, 16'h0001);
      rd(8'h44);
      check("csr", r.rdata, csr_view());
      check("alias", capability_test_alias, cap_m);
      check("sel", {12'h0, data_select}, {12'h0, sel[3:0]});
      check("state", {14'h0, power_state_field}, {14'h0, state[1:0]});
      check("wake_n", {15'h0, wake_n}, {15'h0, ~(status[0] & en[0])});
   endtask

   // Power-on values of the model
   task automatic model_por();
      cap_m = 16'h0001;
      status = 0;
      en = 0;
      sel = 0;
      state = 0;
   endtask

   // Watchdog against a hang
   initial
   begin
      #500000;
      err_count++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      seed = 15142;
      err_count = 0;
      comparisons = 0;
      {srst, hw_reset, sw_reset, stop_cmd, eeprom_load, test_alias_wr, wake_event} = 7'h40;
      {eeprom_cap_word, test_alias_wdata, data_scale} = 34'h0;
      model_por();
      repeat (6) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      check_all();
      wr(8'h44, 2'h3, 16'h8000);
      // Corner words first: clock and aux flags without any wake support, then with D3cold wake only
      for (i = 0; i < 10; i++)
      begin
         w = (i == 0) ? 16'h0018 : (i == 1) ? 16'h8018 : 16'($random(seed));
         @(negedge clk);
         eeprom_load = 1'b1;
         eeprom_cap_word = w;
         @(negedge clk);
         eeprom_load = 1'b0;
         eeprom_cap_word = ~w;
         cap_m = w;
         rd(8'h43);
         check("cap_odd", r.rdata, cap_view());
         wr(8'h42, 2'h3, ~w);
         check_all();
      end
      // Test path rewrites the same storage
      w = 16'($random(seed));
      @(negedge clk);
      test_alias_wr = 1'b1;
      test_alias_wdata = w;
      @(negedge clk);
      test_alias_wr = 1'b0;
      test_alias_wdata = ~w;
      cap_m = w;
      check_all();
      // Random wake events and partial-lane writes
      for (i = 0; i < 24; i++)
      begin
         d = 16'($random(seed));
         b = 2'($random(seed));
         @(negedge clk);
         data_scale = d[6:5];
         wake_event = d[2];
         @(negedge clk);
         wake_event = 1'b0;
         if (d[2])
            status = 1;
         check_all();
         wr(8'h44, b, d);
         check_all();
      end
      // Sticky fields against the non-power-on resets
      @(negedge clk);
      wake_event = 1'b1;
      @(negedge clk);
      wake_event = 1'b0;
      status = 1;
      wr(8'h44, 2'h3, 16'h1703);
      check_all();
      @(negedge clk);
      sw_reset = 1'b1;
      stop_cmd = 1'b1;
      @(negedge clk);
      sw_reset = 1'b0;
      stop_cmd = 1'b0;
      check_all();
      @(negedge clk);
      hw_reset = 1'b1;
      @(negedge clk);
      hw_reset = 1'b0;
      state = 0;
      check_all();
      // Event and clear taken on one edge: the set must win
      fork
         host.access(1'b0, 1'b1, 8'h44, 2'h2, 16'h8100, r);
         begin
            @(negedge clk);
            wake_event = 1'b1;
            @(negedge clk);
            wake_event = 1'b0;
         end
      join
      check("clr_ack", {15'h0, r.ack}, 16'h0001);
      sel = 0;
      en = 1;
      status = 1;
      check_all();
      // Unmapped offset answers without a hit
      rd(8'h50);
      check("miss", {r.hit, r.rdata[14:0]}, 16'h0000);
      // Power-on reset in mid-run returns every register to its power-on value
      @(negedge clk);
      srst = 1'b1;
      @(negedge clk);
      srst = 1'b0;
      model_por();
      check_all();
      complete_run();
   end
endmodule // pmcap_regs_tb_top
